// ===== src/rad_pkg.sv
// Shared constants for the region attribute decoder
// Function
// - Size code zero disables; decode block sizes.
// - Unmapped addresses use local bus; caching follows the pins only while range 7 is off.
// - Conflicting overlaps: uncached, strong, local bus.
// - Ranges 0-6: bit 0 set means uncached.
// - Range 7: bit 0 caches; outside uncached.
// - Bit 1 allows weak write order, write-back.
// - Bit 2 negates lock pin, with exceptions.
// - Weak lock may cache; global bit too.
// - Bit 3 gathers sequential writes, eight bytes.
// - Gathering works cached and uncached alike.
// - Bit 4 makes cacheable region write-through.
// - Bit 5 suppresses local bus indicator.
// - Attribute bits 6 and 7 reserved.
// - Identification registers read-only via index/data.
// - Device number; stepping and revision nibbles.
package rad_pkg;
   localparam int          RAD_NUM_RANGES   = 8;
   localparam int          RAD_MAIN_RANGE   = 7;
   // I/O ports of the index/data pair
   localparam logic [7:0]  RAD_PORT_INDEX   = 8'h22;
   localparam logic [7:0]  RAD_PORT_DATA    = 8'h23;
   // Register indices
   localparam logic [7:0]  RAD_IDX_DEVICE   = 8'hFE;
   localparam logic [7:0]  RAD_IDX_STEPREV  = 8'hFF;
   localparam logic [7:0]  RAD_IDX_ARR_BASE = 8'hC4;
   localparam logic [7:0]  RAD_ARR_STRIDE   = 8'h03;
   localparam logic [7:0]  RAD_IDX_RCR_BASE = 8'hDC;
   localparam logic [7:0]  RAD_IDX_CFG      = 8'hE8;
   // Attribute bit positions
   localparam int          RAD_ATTR_CACHE   = 0;
   localparam int          RAD_ATTR_WWO     = 1;
   localparam int          RAD_ATTR_WL      = 2;
   localparam int          RAD_ATTR_WG      = 3;
   localparam int          RAD_ATTR_WT      = 4;
   localparam int          RAD_ATTR_NLB     = 5;
   localparam logic [7:0]  RAD_ATTR_MASK    = 8'h3F;
   localparam int          RAD_CFG_WLOCK    = 4;
   localparam logic [7:0]  RAD_CFG_MASK     = 8'h10;
   // Size codes
   localparam logic [3:0]  RAD_SIZE_OFF     = 4'h0;
   localparam logic [3:0]  RAD_SIZE_FULL    = 4'hF;
   localparam logic [4:0]  RAD_MAIN_SHIFT   = 5'h06;
   // Access sizes
   localparam logic [1:0]  RAD_ACC_BYTE     = 2'h0;
   localparam logic [1:0]  RAD_ACC_WORD     = 2'h1;
   localparam logic [1:0]  RAD_ACC_DWORD    = 2'h2;
   // Reset values
   localparam logic [7:0]  RAD_RCR_RESET    = 8'h00;
   localparam logic [19:0] RAD_START_RESET  = 20'h00000;
   localparam logic [7:0]  RAD_CFG_RESET    = 8'h00;
endpackage

// ===== src/rad_range_match.sv
// Address match for one programmable range
`timescale 1ns/1ps
module rad_range_match
   import rad_pkg::*;
#(
   parameter bit IS_MAIN = 1'b0
) (
   input  wire logic [19:0] start,
   input  wire logic [3:0]  size,
   input  wire logic [19:0] page,
   output logic             hit
);
   logic [4:0]  shift;
   logic [19:0] mask;

   // Block size as a count of ignored 4 KByte page bits
   always_comb begin
      shift = 5'({1'b0, size} - 5'h01) + (IS_MAIN ? RAD_MAIN_SHIFT : 5'h00);
      if (size == RAD_SIZE_FULL) begin
         mask = '0;
      end else begin
         mask = ~20'((20'h00001 << shift) - 20'h00001);
      end
      // Ignored bits of a misaligned start are masked off, so it matches its aligned block
      hit = (size != RAD_SIZE_OFF) && (((page ^ start) & mask) == '0);
   end
endmodule

// ===== src/rad_write_gather.sv
// Eight-byte write gathering buffer toward the 64-bit bus
`timescale 1ns/1ps
module rad_write_gather
   import rad_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        wr_valid,
   input  wire logic        gather_en,
   input  wire logic [31:0] wr_addr,
   input  wire logic [1:0]  wr_size,
   input  wire logic [31:0] wr_data,
   output logic             bus_wr_valid,
   output logic [28:0]      bus_wr_addr,
   output logic [63:0]      bus_wr_data,
   output logic [7:0]       bus_wr_be
);
   logic        active;
   logic        pending;
   logic [28:0] buf_qw;
   logic [63:0] buf_data;
   logic [7:0]  buf_be;
   logic [31:0] next_seq;
   logic [7:0]  new_be;
   logic [63:0] new_data;
   logic [31:0] bytes;
   logic        seq;
   logic [7:0]  merged_be;
   logic [63:0] merged_data;

   // Lane placement of the incoming write
   always_comb begin
      unique case (wr_size)
         RAD_ACC_BYTE:  bytes = 32'h00000001;
         RAD_ACC_WORD:  bytes = 32'h00000002;
         default:       bytes = 32'h00000004;
      endcase
      new_be   = 8'(((9'h001 << bytes[3:0]) - 9'h001) << wr_addr[2:0]);
      new_data = 64'({32'h00000000, wr_data} << {wr_addr[2:0], 3'h0});
      seq      = active && !pending && gather_en && (wr_addr == next_seq)
                 && (wr_addr[31:3] == buf_qw);
      merged_be = buf_be | new_be;
      merged_data = buf_data;
      for (int i = 0; i < 8; i++) begin
         if (new_be[i]) begin
            merged_data[i*8 +: 8] = new_data[i*8 +: 8];
         end
      end
   end

   // One bus write at most per cycle; a buffer that cannot gather is emitted late
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active       <= 1'b0;
         pending      <= 1'b0;
         buf_qw       <= '0;
         buf_data     <= '0;
         buf_be       <= '0;
         next_seq     <= '0;
         bus_wr_valid <= 1'b0;
         bus_wr_addr  <= '0;
         bus_wr_data  <= '0;
         bus_wr_be    <= '0;
      end else begin
         bus_wr_valid <= 1'b0;
         if (wr_valid && seq) begin
            if (&merged_be) begin
               bus_wr_valid <= 1'b1;
               bus_wr_addr  <= buf_qw;
               bus_wr_data  <= merged_data;
               bus_wr_be    <= merged_be;
               active       <= 1'b0;
            end else begin
               buf_be   <= merged_be;
               buf_data <= merged_data;
               next_seq <= wr_addr + bytes;
            end
         end else if (wr_valid) begin
            if (active) begin
               bus_wr_valid <= 1'b1;
               bus_wr_addr  <= buf_qw;
               bus_wr_data  <= buf_data;
               bus_wr_be    <= buf_be;
            end
            active   <= 1'b1;
            pending  <= !gather_en;
            buf_qw   <= wr_addr[31:3];
            buf_data <= new_data;
            buf_be   <= new_be;
            next_seq <= wr_addr + bytes;
         end else if (active && pending) begin
            bus_wr_valid <= 1'b1;
            bus_wr_addr  <= buf_qw;
            bus_wr_data  <= buf_data;
            bus_wr_be    <= buf_be;
            active       <= 1'b0;
         end
      end
   end
endmodule

// ===== src/region_attribute_decoder.sv
// Region attribute decoder: range registers, attribute resolution, write gathering
`timescale 1ns/1ps
module rad_region_attribute_decoder
   import rad_pkg::*;
#(
   parameter logic [7:0] DEVICE_NUMBER   = 8'h5A, // Arbitrary value
   parameter logic [3:0] STEPPING_NUMBER = 4'h1,  // Arbitrary value
   parameter logic [3:0] REVISION_NUMBER = 4'h2   // Arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_port,
   input  wire logic [7:0]  io_wdata,
   output logic [7:0]       io_rdata,
   input  wire logic        acc_valid,
   input  wire logic [31:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic [1:0]  acc_size,
   input  wire logic [31:0] acc_wdata,
   input  wire logic        acc_locked,
   input  wire logic        acc_page_table,
   input  wire logic        acc_inta,
   input  wire logic        global_cache_off,
   input  wire logic        cache_enable_in_n,
   input  wire logic        write_policy_in,
   output logic             attr_valid,
   output logic             local_bus_ind_n,
   output logic             lock_out_n,
   output logic             locked_internal,
   output logic             cacheable,
   output logic             write_back,
   output logic             weak_write_order,
   output logic             region_hit,
   output logic             region_conflict,
   output logic             bus_wr_valid,
   output logic [28:0]      bus_wr_addr,
   output logic [63:0]      bus_wr_data,
   output logic [7:0]       bus_wr_be
);
   logic [7:0]  index;
   logic [19:0] range_start [RAD_NUM_RANGES];
   logic [3:0]  range_size  [RAD_NUM_RANGES];
   logic [7:0]  region_attributes [RAD_NUM_RANGES];
   logic [7:0]  config_control_1;
   logic [RAD_NUM_RANGES-1:0] hits;
   logic [5:0]  norm_attr [RAD_NUM_RANGES];
   logic [2:0]  ken_sync;
   logic [2:0]  wp_sync;
   logic        ken_ok;
   logic        wp_ok;
   logic        any_hit;
   logic        conflict;
   logic [5:0]  sel_attr;
   logic        main_defined;
   logic        r_lb;
   logic        r_cache;
   logic        r_wb;
   logic        r_wg;
   logic        r_wl;
   logic        r_wwo;
   logic        weak_eff;
   logic        next_cacheable;
   logic        next_lock_pin;
   logic        next_lock_int;
   logic [7:0]  next_rdata;
   logic        data_wr;

   assign data_wr = io_wr && (io_port == RAD_PORT_DATA);

   // Pin inputs: three stages, a change counts once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ken_sync <= 3'h7;
         wp_sync  <= 3'h0;
         ken_ok   <= 1'b0;
         wp_ok    <= 1'b0;
      end else begin
         ken_sync <= {ken_sync[1:0], cache_enable_in_n};
         wp_sync  <= {wp_sync[1:0], write_policy_in};
         if (ken_sync[1] == ken_sync[2]) begin
            ken_ok <= !ken_sync[2];
         end
         if (wp_sync[1] == wp_sync[2]) begin
            wp_ok <= wp_sync[2];
         end
      end
   end

   // Index latch for the index/data port pair
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         index <= 8'h00;
      end else if (io_wr && (io_port == RAD_PORT_INDEX)) begin
         index <= io_wdata;
      end
   end

   // Range and attribute storage; identification indices have no storage and ignore writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int n = 0; n < RAD_NUM_RANGES; n++) begin
            range_start[n]       <= RAD_START_RESET;
            range_size[n]        <= RAD_SIZE_OFF;
            region_attributes[n] <= RAD_RCR_RESET;
         end
         config_control_1 <= RAD_CFG_RESET;
      end else if (data_wr) begin
         for (int n = 0; n < RAD_NUM_RANGES; n++) begin
            if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n)) begin
               range_start[n][19:12] <= io_wdata;
            end
            if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n + 1)) begin
               range_start[n][11:4] <= io_wdata;
            end
            if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n + 2)) begin
               range_start[n][3:0] <= io_wdata[7:4];
               range_size[n]       <= io_wdata[3:0];
            end
            if (index == 8'(RAD_IDX_RCR_BASE + n)) begin
               region_attributes[n] <= io_wdata & RAD_ATTR_MASK;
            end
         end
         if (index == RAD_IDX_CFG) begin
            config_control_1 <= io_wdata & RAD_CFG_MASK;
         end
      end
   end

   // Read data multiplexer; unmapped indices read as zero
   always_comb begin
      next_rdata = 8'h00;
      for (int n = 0; n < RAD_NUM_RANGES; n++) begin
         if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n)) begin
            next_rdata = range_start[n][19:12];
         end
         if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n + 1)) begin
            next_rdata = range_start[n][11:4];
         end
         if (index == 8'(RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n + 2)) begin
            next_rdata = {range_start[n][3:0], range_size[n]};
         end
         if (index == 8'(RAD_IDX_RCR_BASE + n)) begin
            next_rdata = region_attributes[n];
         end
      end
      if (index == RAD_IDX_CFG) begin
         next_rdata = config_control_1;
      end
      if (index == RAD_IDX_DEVICE) begin
         next_rdata = DEVICE_NUMBER;
      end
      if (index == RAD_IDX_STEPREV) begin
         next_rdata = {STEPPING_NUMBER, REVISION_NUMBER};
      end
   end

   // Read data holds until the next data-port read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata <= 8'h00;
      end else if (io_rd && (io_port == RAD_PORT_DATA)) begin
         io_rdata <= next_rdata;
      end
   end

   // All eight comparators evaluate every access at once
   generate
      for (genvar g = 0; g < RAD_NUM_RANGES; g++) begin : g_range
         rad_range_match #(
            .IS_MAIN (g == RAD_MAIN_RANGE)
         ) u_match (
            .start (range_start[g]),
            .size  (range_size[g]),
            .page  (acc_addr[31:12]),
            .hit   (hits[g])
         );
         // Bit 0 normalised to a cacheable sense so overlaps compare alike
         assign norm_attr[g] = (g == RAD_MAIN_RANGE) ?
                               region_attributes[g][5:0] :
                               {region_attributes[g][5:1], ~region_attributes[g][RAD_ATTR_CACHE]};
      end
   endgenerate

   // Overlap detection against the first matching range
   always_comb begin
      any_hit  = |hits;
      sel_attr = '0;
      conflict = 1'b0;
      for (int n = RAD_NUM_RANGES - 1; n >= 0; n--) begin
         if (hits[n]) begin
            sel_attr = norm_attr[n];
         end
      end
      for (int n = 0; n < RAD_NUM_RANGES; n++) begin
         if (hits[n] && (norm_attr[n] != sel_attr)) begin
            conflict = 1'b1;
         end
      end
      main_defined = (range_size[RAD_MAIN_RANGE] != RAD_SIZE_OFF);
   end

   // Region attribute resolution
   always_comb begin
      if (!any_hit) begin
         r_lb    = 1'b1;
         r_cache = ken_ok && !main_defined;
         r_wb    = wp_ok;
         r_wg    = 1'b0;
         r_wl    = 1'b0;
         r_wwo   = 1'b0;
      end else if (conflict) begin
         r_lb    = 1'b1;
         r_cache = 1'b0;
         r_wb    = 1'b0;
         r_wg    = 1'b0;
         r_wl    = 1'b0;
         r_wwo   = 1'b0;
      end else begin
         r_lb    = !sel_attr[RAD_ATTR_NLB];
         r_cache = sel_attr[RAD_ATTR_CACHE];
         r_wb    = sel_attr[RAD_ATTR_CACHE] && !sel_attr[RAD_ATTR_WT];
         r_wg    = sel_attr[RAD_ATTR_WG];
         r_wl    = sel_attr[RAD_ATTR_WL];
         // Applies to write-back data even while caching is globally off
         r_wwo   = sel_attr[RAD_ATTR_WWO] && r_wb;
      end
      weak_eff = r_wl || config_control_1[RAD_CFG_WLOCK];
      // A strongly locked cycle is never cached; a weak one may be
      next_cacheable = r_cache && !global_cache_off && !(acc_locked && !weak_eff);
      next_lock_pin  = acc_locked && (!weak_eff || acc_page_table);
      next_lock_int  = acc_locked && (!weak_eff || acc_page_table || acc_inta);
   end

   // Registered attribute outputs, one cycle after the access
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         attr_valid       <= 1'b0;
         local_bus_ind_n  <= 1'b1;
         lock_out_n       <= 1'b1;
         locked_internal  <= 1'b0;
         cacheable        <= 1'b0;
         write_back       <= 1'b0;
         weak_write_order <= 1'b0;
         region_hit       <= 1'b0;
         region_conflict  <= 1'b0;
      end else begin
         attr_valid <= acc_valid;
         if (acc_valid) begin
            local_bus_ind_n  <= !r_lb;
            lock_out_n       <= !next_lock_pin;
            locked_internal  <= next_lock_int;
            cacheable        <= next_cacheable;
            write_back       <= r_wb && next_cacheable;
            weak_write_order <= r_wwo;
            region_hit       <= any_hit;
            region_conflict  <= any_hit && conflict;
         end
      end
   end

   // Writes pass through the gathering buffer; bus order stays program order
   rad_write_gather u_gather (
      .clk          (clk),
      .arst_n       (arst_n),
      .wr_valid     (acc_valid && acc_write),
      .gather_en    (r_wg),
      .wr_addr      (acc_addr),
      .wr_size      (acc_size),
      .wr_data      (acc_wdata),
      .bus_wr_valid (bus_wr_valid),
      .bus_wr_addr  (bus_wr_addr),
      .bus_wr_data  (bus_wr_data),
      .bus_wr_be    (bus_wr_be)
   );
endmodule

// ===== testbench/rad_bus_partner.sv
// Chipset model: cache pins, bus write capture
`timescale 1ns/1ps
module rad_bus_partner (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        bus_wr_valid,
   input  wire logic [28:0] bus_wr_addr,
   input  wire logic [63:0] bus_wr_data,
   input  wire logic [7:0]  bus_wr_be,
   input  wire logic        ken_on,
   input  wire logic        wb_hi,
   output logic             cache_enable_in_n,
   output logic             write_policy_in,
   output int               wr_cnt,
   output logic [28:0]      last_addr,
   output logic [63:0]      last_data,
   output logic [7:0]       last_be
);
   // Steady levels so the pin syncs settle
   assign cache_enable_in_n = !ken_on;
   assign write_policy_in   = wb_hi;
   // One pulse, one bus write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_cnt <= 0;
      end else if (bus_wr_valid) begin
         wr_cnt    <= wr_cnt + 1;
         last_addr <= bus_wr_addr;
         last_data <= bus_wr_data;
         last_be   <= bus_wr_be;
      end
   end
endmodule

// ===== testbench/rad_checker_asserts.sv
// Assertions on the decoder's ports
`timescale 1ns/1ps
module rad_checker
   import rad_pkg::*;
(
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       io_rd,
   input wire logic [7:0] io_port,
   input wire logic [7:0] io_rdata,
   input wire logic       acc_valid,
   input wire logic       acc_locked,
   input wire logic       acc_page_table,
   input wire logic       acc_inta,
   input wire logic       attr_valid,
   input wire logic       local_bus_ind_n,
   input wire logic       lock_out_n,
   input wire logic       locked_internal,
   input wire logic       cacheable,
   input wire logic       write_back,
   input wire logic       weak_write_order,
   input wire logic       region_hit,
   input wire logic       region_conflict,
   input wire logic       bus_wr_valid,
   input wire logic [7:0] bus_wr_be
);
   // One clock domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Answer timing
   a_attr_pulse: assert property (acc_valid |=> attr_valid)
      else $error("no answer");
   a_attr_quiet: assert property (!acc_valid |=> !attr_valid && $stable(cacheable) && $stable(region_hit))
      else $error("outputs moved");
   // Precedence cases
   a_conflict_strong: assert property (attr_valid && region_conflict |->
      !cacheable && !write_back && !weak_write_order && !local_bus_ind_n)
      else $error("bad conflict");
   a_unmapped_lb: assert property (attr_valid && !region_hit |->
      !local_bus_ind_n && !weak_write_order && !region_conflict)
      else $error("bad unmapped");
   a_wb_cached: assert property (attr_valid && write_back |-> cacheable)
      else $error("wb uncached");
   a_wwo_wb: assert property (attr_valid && weak_write_order |-> write_back)
      else $error("wwo without wb");
   // Lock pin and internal lock relations
   a_unlocked_pin: assert property (acc_valid && !acc_locked |=> lock_out_n && !locked_internal)
      else $error("stray lock");
   a_pt_lock: assert property (acc_valid && acc_locked && acc_page_table |=> !lock_out_n)
      else $error("pt not locked");
   a_inta_lock: assert property (acc_valid && acc_locked && acc_inta |=> locked_internal)
      else $error("inta not locked");
   // Register port, bus
   a_rdata_hold: assert property (!(io_rd && io_port == RAD_PORT_DATA) |=> $stable(io_rdata))
      else $error("rdata moved");
   a_bus_lanes: assert property (bus_wr_valid |-> bus_wr_be != 8'h00)
      else $error("no lanes");

   c_conflict: cover property (attr_valid && region_conflict);
   c_full_qword: cover property (bus_wr_valid && bus_wr_be == 8'hFF);
   c_weak_inta: cover property (acc_valid && acc_locked && acc_inta ##1 lock_out_n);
endmodule

bind rad_region_attribute_decoder rad_checker u_chk (.clk, .arst_n, .io_rd, .io_port, .io_rdata, .acc_valid,
   .acc_locked, .acc_page_table, .acc_inta, .attr_valid, .local_bus_ind_n, .lock_out_n, .locked_internal,
   .cacheable, .write_back, .weak_write_order, .region_hit, .region_conflict, .bus_wr_valid, .bus_wr_be);

// ===== testbench/region_attribute_decoder_tb.sv
// Bench for the region attribute decoder
`timescale 1ns/1ps
module region_attribute_decoder_tb
   import rad_pkg::*;
;
   localparam logic [7:0] DEV = 8'h3C; // Arbitrary value
   localparam logic [3:0] STP = 4'h4;  // Arbitrary value
   localparam logic [3:0] REV = 4'h7;  // Arbitrary value
   logic        clk, arst_n, attr_valid, local_bus_ind_n, lock_out_n, locked_internal;
   logic        cacheable, write_back, weak_write_order, region_hit, region_conflict, bus_wr_valid;
   logic        io_wr = 1'b0, io_rd = 1'b0, acc_valid = 1'b0, acc_write = 1'b0, acc_locked = 1'b0;
   logic        acc_page_table = 1'b0, acc_inta = 1'b0, global_cache_off = 1'b0;
   logic        ken_on = 1'b1, wb_hi = 1'b1, cache_enable_in_n, write_policy_in;
   logic [7:0]  io_port = 8'h00, io_wdata = 8'h00, io_rdata, bus_wr_be, last_be;
   logic [31:0] acc_addr = 32'h0, acc_wdata = 32'h0;
   logic [1:0]  acc_size = 2'h0;
   logic [28:0] bus_wr_addr, last_addr;
   logic [63:0] bus_wr_data, last_data;
   int          wr_cnt, err_count = 0, samples_checked = 0, cyc = 0;

   rad_region_attribute_decoder #(.DEVICE_NUMBER(DEV), .STEPPING_NUMBER(STP), .REVISION_NUMBER(REV)) dut (
      .clk, .arst_n, .io_wr, .io_rd, .io_port, .io_wdata, .io_rdata, .acc_valid, .acc_addr, .acc_write,
      .acc_size, .acc_wdata, .acc_locked, .acc_page_table, .acc_inta, .global_cache_off, .cache_enable_in_n,
      .write_policy_in, .attr_valid, .local_bus_ind_n, .lock_out_n, .locked_internal, .cacheable, .write_back,
      .weak_write_order, .region_hit, .region_conflict, .bus_wr_valid, .bus_wr_addr, .bus_wr_data, .bus_wr_be);
   rad_bus_partner u_far (.clk, .arst_n, .bus_wr_valid, .bus_wr_addr, .bus_wr_data, .bus_wr_be, .ken_on,
      .wb_hi, .cache_enable_in_n, .write_policy_in, .wr_cnt, .last_addr, .last_data, .last_be);

   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      chk(64'(g), 64'(e));
   endtask
   // Inputs change at falling edges
   task automatic iow(input logic [7:0] p, input logic [7:0] d);
      @(negedge clk);
      io_wr = 1'b1;
      io_port = p;
      io_wdata = d;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   task automatic cfg(input logic [7:0] i, input logic [7:0] d);
      iow(RAD_PORT_INDEX, i);
      iow(RAD_PORT_DATA, d);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      iow(RAD_PORT_INDEX, i);
      @(negedge clk);
      io_rd = 1'b1;
      io_port = RAD_PORT_DATA;
      @(negedge clk);
      io_rd = 1'b0;
      chk(64'(io_rdata), 64'(e));
   endtask
   task automatic set_range(input logic [7:0] n, input logic [31:0] s, input logic [3:0] sz, input logic [7:0] at);
      logic [7:0] b;
      b = RAD_IDX_ARR_BASE + RAD_ARR_STRIDE * n;
      cfg(b, s[31:24]);
      cfg(b + 8'h01, s[23:16]);
      cfg(b + 8'h02, {s[15:12], sz});
      cfg(RAD_IDX_RCR_BASE + n, at);
   endtask
   // e = {hit, lb_n, cache, wb}
   task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [31:0] d,
                      input logic [2:0] c, input logic [3:0] e);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_addr = a;
      acc_write = w;
      acc_size = sz;
      acc_wdata = d;
      {acc_locked, acc_page_table, acc_inta} = c;
      @(negedge clk);
      acc_valid = 1'b0;
      chk_flag(attr_valid, 1'b1);
      chk(64'({region_hit, local_bus_ind_n, cacheable, write_back}), 64'(e));
   endtask
   task automatic rda(input logic [31:0] a, input logic [2:0] c, input logic [3:0] e);
      acc(a, 1'b0, RAD_ACC_DWORD, 32'h0, c, e);
   endtask
   task automatic pins(input logic k, input logic w);
      ken_on = k;
      wb_hi = w;
      repeat (4) @(negedge clk);
   endtask

   task automatic t_ident();
      rd(RAD_IDX_DEVICE, DEV);
      cfg(RAD_IDX_DEVICE, 8'hA5);
      rd(RAD_IDX_DEVICE, DEV);
      rd(RAD_IDX_STEPREV, {STP, REV});
      rd(8'h80, 8'h00);
      cfg(RAD_IDX_RCR_BASE, 8'hFF);
      rd(RAD_IDX_RCR_BASE, 8'h3F);
      $display("test ident done");
   endtask
   task automatic t_unmapped();
      rda(32'h0050_0000, 3'b000, 4'b0011);
      pins(1'b0, 1'b1);
      rda(32'h0050_0000, 3'b000, 4'b0000);
      pins(1'b1, 1'b0);
      rda(32'h0050_0000, 3'b000, 4'b0010);
      pins(1'b1, 1'b1);
      $display("test unmapped done");
   endtask
   task automatic t_ranges();
      set_range(8'h00, 32'h0002_0000, 4'h2, 8'h01);
      rda(32'h0002_1FFC, 3'b000, 4'b1000);
      rda(32'h0002_2000, 3'b000, 4'b0011);
      rda(32'h0001_FFFC, 3'b000, 4'b0011);
      set_range(8'h02, 32'h0040_0000, 4'h1, 8'h30);
      rda(32'h0040_0FFF, 3'b000, 4'b1110);
      global_cache_off = 1'b1;
      rda(32'h0040_0FFF, 3'b000, 4'b1100);
      global_cache_off = 1'b0;
      set_range(8'h03, 32'h0050_0000, 4'h1, 8'h02);
      rda(32'h0050_0010, 3'b000, 4'b1011);
      chk_flag(weak_write_order, 1'b1);
      cfg(RAD_IDX_RCR_BASE + 8'h03, 8'h12);
      rda(32'h0050_0010, 3'b000, 4'b1010);
      chk_flag(weak_write_order, 1'b0);
      $display("test ranges done");
   endtask
   task automatic t_conflict();
      set_range(8'h04, 32'h0002_0000, 4'h1, 8'h00);
      rda(32'h0002_0800, 3'b000, 4'b1000);
      chk_flag(region_conflict, 1'b1);
      cfg(RAD_IDX_RCR_BASE + 8'h04, 8'h01);
      rda(32'h0002_0800, 3'b000, 4'b1000);
      chk_flag(region_conflict, 1'b0);
      $display("test conflict done");
   endtask
   task automatic t_lock();
      set_range(8'h05, 32'h0060_0000, 4'h1, 8'h04);
      rda(32'h0060_0000, 3'b100, 4'b1011);
      chk_flag(lock_out_n, 1'b1);
      rda(32'h0060_0000, 3'b110, 4'b1011);
      chk_flag(lock_out_n, 1'b0);
      rda(32'h0060_0000, 3'b101, 4'b1011);
      chk_flag(lock_out_n, 1'b1);
      chk_flag(locked_internal, 1'b1);
      rda(32'h00A0_0000, 3'b100, 4'b0000);
      chk_flag(lock_out_n, 1'b0);
      cfg(RAD_IDX_CFG, 8'h10);
      rda(32'h00A0_0000, 3'b100, 4'b0011);
      chk_flag(lock_out_n, 1'b1);
      cfg(RAD_IDX_CFG, 8'h00);
      $display("test lock done");
   endtask
   task automatic t_gather();
      set_range(8'h01, 32'h0000_1000, 4'h1, 8'h08);
      for (int i = 0; i < 8; i++) acc(32'h1000 + 32'(i), 1'b1, RAD_ACC_BYTE, 32'h11 + 32'(i), 3'b000, 4'b1011);
      repeat (3) @(negedge clk);
      chk(64'(wr_cnt), 64'h1);
      chk(64'(last_be), 64'hFF);
      chk(64'(last_addr), 64'h200);
      chk(last_data, 64'h1817_1615_1413_1211);
      set_range(8'h06, 32'h0000_3000, 4'h1, 8'h09);
      acc(32'h3000, 1'b1, RAD_ACC_DWORD, 32'h4433_2211, 3'b000, 4'b1000);
      acc(32'h3004, 1'b1, RAD_ACC_DWORD, 32'h8877_6655, 3'b000, 4'b1000);
      repeat (3) @(negedge clk);
      chk(64'(last_addr), 64'h600);
      chk(last_data, 64'h8877_6655_4433_2211);
      acc(32'h9000, 1'b1, RAD_ACC_WORD, 32'hBEEF, 3'b000, 4'b0011);
      repeat (3) @(negedge clk);
      chk(64'(wr_cnt), 64'h3);
      chk(64'(last_be), 64'h03);
      $display("test gather done");
   endtask
   task automatic t_main();
      set_range(8'h07, 32'h0000_0000, 4'h1, 8'h01);
      rda(32'h0003_0000, 3'b000, 4'b1011);
      rda(32'h0004_0000, 3'b000, 4'b0000);
      $display("test main done");
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Reset, then scenarios
   initial begin
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      t_ident();
      t_unmapped();
      t_ranges();
      t_conflict();
      t_lock();
      t_gather();
      t_main();
      complete_run();
   end
endmodule
